// ===== rtl/sib_pkg.sv
// Shared constants and types of the indexed block serial target.
package sib_pkg;

    // Register file geometry.
    localparam int         REG_DEPTH   = 16;
    localparam int         IDX_W       = 4;
    localparam logic [7:0] DEPTH_LIMIT = 8'h10;

    // Byte offsets with special meaning.
    localparam logic [7:0] COUNT_IDX = 8'h07;
    localparam logic [7:0] LOCK_IDX  = 8'h08;

    // Field positions inside the lock byte.
    localparam int LOCK_BIT   = 0;
    localparam int STICKY_BIT = 1;

    // Reset values and the idle byte.
    localparam logic [7:0] COUNT_RESET = 8'h08;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam logic [7:0] IDLE_BYTE   = 8'hff;

    // Seven-bit target address on the serial bus.
    localparam logic [6:0] TARGET_ADDR = 7'h6c;

    // Bit counter limits.
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Byte engine states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_RX    = 5'h02,
        ST_RXACK = 5'h04,
        ST_TX    = 5'h08,
        ST_TXACK = 5'h10
    } sib_state_t;

    // Meaning of the next byte of a transaction.
    typedef enum logic [1:0] {
        ROLE_ADDR   = 2'h0,
        ROLE_OFFSET = 2'h1,
        ROLE_COUNT  = 2'h2,
        ROLE_DATA   = 2'h3
    } sib_role_t;

endpackage

// ===== rtl/sib_regfile.sv
`timescale 1ns/1ps
`default_nettype none

// Small byte memory with one write port and a registered read port.
module sib_regfile
    import sib_pkg::*;
(
    // Clock and reset.
    input  wire logic                    sys_clk,
    input  wire logic                    reset,
    // Write port.
    input  wire logic                    wrEn,
    input  wire logic [sib_pkg::IDX_W-1:0] wrAddr,
    input  wire logic [7:0]              wrData,
    // Read port.
    input  wire logic [sib_pkg::IDX_W-1:0] rdAddr,
    output logic      [7:0]              rdData
);

    // Whole memory state, entries and the read register.
    typedef struct packed {
        logic [REG_DEPTH-1:0][7:0] mem;
        logic [7:0]                rd;
    } sib_mem_t;

    sib_mem_t                       r;       // Registered state.
    sib_mem_t                       next_r;  // Next state.
    wire logic [REG_DEPTH-1:0][7:0] memNext; // Next contents per entry.

    assign rdData = r.rd;

    // Each entry takes a write only when addressed. One net per entry keeps
    // the single combinational process below the only writer of next_r.
    genvar i;
    generate
        for (i = 0; i < REG_DEPTH; i++) begin : g_entry
            assign memNext[i] = (wrEn && (wrAddr == IDX_W'(i))) ? wrData
                                                                : r.mem[i];
        end
    endgenerate

    // Read data always comes from a flop, one cycle behind the address.
    always_comb begin
        next_r     = r;
        next_r.mem = memNext;
        next_r.rd  = r.mem[rdAddr];
    end

    // The count byte resets to its own value so reads report it at once.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int k = 0; k < REG_DEPTH; k++) begin
                r.mem[k] <= (k == int'(COUNT_IDX)) ? COUNT_RESET : DATA_RESET;
            end
            r.rd <= DATA_RESET;
        end else begin
            r <= next_r;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/sib_target.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Acknowledge own address, then the offset byte.
// - Count byte follows offset and is acknowledged.
// - Store data at N up to N+X-1.
// - Return count first, then bytes from N.
// - Read count comes from register byte 7.
// - Protected when lock or sticky lock set.
// - Port idle unless power-good input is high.
module sib_target
    import sib_pkg::*;
(
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic reset,
    // Serial bus pins, data is open drain.
    input  wire logic sclIn,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOeN,
    // Power state pin.
    input  wire logic powerGoodPowerdownN,
    // Local control and status.
    input  wire logic stickyLockSet,
    output logic      writeProtected
);

    // Entire state of the target in one record.
    typedef struct packed {
        sib_state_t state;
        sib_role_t  role;
        logic       scl1;
        logic       scl2;
        logic       scl3;
        logic       sda1;
        logic       sda2;
        logic       sda3;
        logic       pg1;
        logic       pg2;
        logic [7:0] shift;
        logic [2:0] bitCnt;
        logic       full;
        logic       rw;
        logic       hostAck;
        logic [7:0] offset;
        logic [7:0] remaining;
        logic [7:0] countReg;
        logic       lock;
        logic       sticky;
        logic       sdaLow;
        logic       memWe;
        logic [7:0] memAddr;
        logic [7:0] memData;
    } sib_regs_t;

    sib_regs_t  r;        // Registered state.
    sib_regs_t  next_r;   // Next state.
    logic [7:0] memRd;    // Registered memory read data.
    logic [7:0] readByte; // Byte presented for the current offset.
    logic       sclRise;  // Clock rose on the bus.
    logic       sclFall;  // Clock fell on the bus.
    logic       startSeen; // Start or repeated start.
    logic       stopSeen;  // Stop condition.
    logic       locked;    // Write protection in force.

    // The pin is only ever pulled low; the enable releases it.
    assign sdaOut         = 1'b0;
    assign sdaOeN         = ~r.sdaLow;
    assign writeProtected = locked;

    // Bus events use only the second and third sync stages.
    assign sclRise   = r.scl2 & ~r.scl3;
    assign sclFall   = ~r.scl2 & r.scl3;
    assign startSeen = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
    assign stopSeen  = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;
    assign locked    = r.lock | r.sticky;

    // Byte store for the configuration bytes.
    sib_regfile sib_regfile_i (
        .sys_clk (sys_clk),
        .reset   (reset),
        .wrEn    (r.memWe),
        .wrAddr  (r.memAddr[IDX_W-1:0]),
        .wrData  (r.memData),
        .rdAddr  (r.offset[IDX_W-1:0]),
        .rdData  (memRd)
    );

    // Lock and count bytes live in flops; offsets past the store read zero.
    always_comb begin
        if (r.offset == LOCK_IDX) begin
            readByte = DATA_RESET;
            readByte[LOCK_BIT]   = r.lock;
            readByte[STICKY_BIT] = r.sticky;
        end else if (r.offset == COUNT_IDX) begin
            readByte = r.countReg;
        end else if (r.offset < DEPTH_LIMIT) begin
            readByte = memRd;
        end else begin
            readByte = DATA_RESET;
        end
    end

    // Byte engine: samples on clock rise, changes the data line on fall.
    always_comb begin
        next_r       = r;
        next_r.scl1  = sclIn;
        next_r.scl2  = r.scl1;
        next_r.scl3  = r.scl2;
        next_r.sda1  = sdaIn;
        next_r.sda2  = r.sda1;
        next_r.sda3  = r.sda2;
        next_r.pg1   = powerGoodPowerdownN;
        next_r.pg2   = r.pg1;
        next_r.memWe = 1'b0;
        if (!r.pg2) begin
            // Without power good the port ignores the bus entirely.
            next_r.state  = ST_IDLE;
            next_r.sdaLow = 1'b0;
        end else if (startSeen) begin
            // A repeated start keeps the offset for the read that follows.
            next_r.state  = ST_RX;
            next_r.role   = ROLE_ADDR;
            next_r.bitCnt = 3'h0;
            next_r.full   = 1'b0;
            next_r.sdaLow = 1'b0;
        end else if (stopSeen) begin
            next_r.state  = ST_IDLE;
            next_r.sdaLow = 1'b0;
        end else begin
            case (r.state)
                ST_RX: begin
                    if (sclRise) begin
                        next_r.shift  = {r.shift[6:0], r.sda2};
                        next_r.bitCnt = r.bitCnt + 3'h1;
                        next_r.full   = (r.bitCnt == BIT_LAST);
                    end else if (sclFall && r.full) begin
                        next_r.full   = 1'b0;
                        next_r.sdaLow = 1'b1;
                        next_r.state  = ST_RXACK;
                        case (r.role)
                            ROLE_ADDR: begin
                                if (r.shift[7:1] == TARGET_ADDR) begin
                                    next_r.rw   = r.shift[0];
                                    next_r.role = r.shift[0] ? ROLE_COUNT
                                                             : ROLE_OFFSET;
                                end else begin
                                    // Another target is addressed.
                                    next_r.sdaLow = 1'b0;
                                    next_r.state  = ST_IDLE;
                                end
                            end
                            ROLE_OFFSET: begin
                                next_r.offset = r.shift;
                                next_r.role   = ROLE_COUNT;
                            end
                            ROLE_COUNT: begin
                                next_r.remaining = r.shift;
                                next_r.role      = ROLE_DATA;
                            end
                            default: begin
                                // Bytes past the count are acknowledged
                                // but dropped.
                                if (r.remaining != 8'h00) begin
                                    next_r.offset    = r.offset + 8'h01;
                                    next_r.remaining = r.remaining - 8'h01;
                                    if (r.offset == LOCK_IDX) begin
                                        next_r.lock = r.shift[LOCK_BIT];
                                        if (r.shift[STICKY_BIT]) begin
                                            next_r.sticky = 1'b0;
                                        end
                                    end else if (!locked &&
                                                 r.offset < DEPTH_LIMIT) begin
                                        next_r.memWe   = 1'b1;
                                        next_r.memAddr = r.offset;
                                        next_r.memData = r.shift;
                                        if (r.offset == COUNT_IDX) begin
                                            next_r.countReg = r.shift;
                                        end
                                    end
                                    // Locked bytes still see the ack above.
                                end
                            end
                        endcase
                    end
                end
                ST_RXACK: begin
                    if (sclFall) begin
                        next_r.bitCnt = 3'h0;
                        if (r.rw) begin
                            // Count byte goes out first on a read.
                            next_r.state     = ST_TX;
                            next_r.shift     = r.countReg;
                            next_r.remaining = r.countReg;
                            next_r.sdaLow    = ~r.countReg[7];
                        end else begin
                            next_r.state  = ST_RX;
                            next_r.sdaLow = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (r.bitCnt == BIT_LAST) begin
                            next_r.state  = ST_TXACK;
                            next_r.sdaLow = 1'b0;
                        end else begin
                            next_r.bitCnt = r.bitCnt + 3'h1;
                            next_r.shift  = {r.shift[6:0], 1'b0};
                            next_r.sdaLow = ~r.shift[6];
                        end
                    end
                end
                ST_TXACK: begin
                    if (sclRise) begin
                        next_r.hostAck = ~r.sda2;
                    end else if (sclFall) begin
                        if (r.hostAck) begin
                            // Past the count the line idles high.
                            next_r.bitCnt = 3'h0;
                            next_r.state  = ST_TX;
                            if (r.remaining != 8'h00) begin
                                next_r.shift     = readByte;
                                next_r.sdaLow    = ~readByte[7];
                                next_r.offset    = r.offset + 8'h01;
                                next_r.remaining = r.remaining - 8'h01;
                            end else begin
                                next_r.shift  = IDLE_BYTE;
                                next_r.sdaLow = 1'b0;
                            end
                        end else begin
                            // Not acknowledged: wait for the stop.
                            next_r.state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    next_r.sdaLow = 1'b0;
                end
            endcase
        end
        // A local set beats a software clear in the same cycle.
        if (stickyLockSet) begin
            next_r.sticky = 1'b1;
        end
    end

    // State register; bus sync stages reset to the idle bus level, power-good stages to low.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            r           <= '0;
            r.state     <= ST_IDLE;
            r.role      <= ROLE_ADDR;
            r.scl1      <= 1'b1;
            r.scl2      <= 1'b1;
            r.scl3      <= 1'b1;
            r.sda1      <= 1'b1;
            r.sda2      <= 1'b1;
            r.sda3      <= 1'b1;
            r.countReg  <= COUNT_RESET;
        end else begin
            r <= next_r;
        end
    end

endmodule

`default_nettype wire

// ===== test/sib_target_assertions.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the serial target's pins for timing and protection relations.
module sib_target_assertions (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // Serial bus pins.
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOeN,
    // Power and protection.
    input wire logic powerGoodPowerdownN,
    input wire logic stickyLockSet,
    input wire logic writeProtected
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // A powered-down port must let go of the data line.
    pg_idle_a: assert property (
        !powerGoodPowerdownN [*5] |-> sdaOeN)
        else $error("data driven while powered down");
    // Power returning must not revive a stale drive.
    pg_rise_a: assert property (
        !powerGoodPowerdownN [*5] ##1 powerGoodPowerdownN |-> sdaOeN [*2])
        else $error("data driven as power returned");
    // The data pin only ever pulls low.
    sda_tied_a: assert property (
        sdaOut == 1'b0)
        else $error("data pin drives high");
    // A pull may only begin while the bus clock is low.
    no_pull_high_a: assert property (
        sclIn [*5] |-> !$fell(sdaOeN))
        else $error("data pulled while clock high");
    // A release may only happen while the bus clock is low.
    no_release_high_a: assert property (
        sclIn [*5] |-> !$rose(sdaOeN))
        else $error("data released while clock high");
    // The set input raises protection on the next cycle.
    sticky_set_a: assert property (
        stickyLockSet |=> writeProtected)
        else $error("sticky set did not protect");
    // Protection does not move without a bus write or a set.
    wp_hold_a: assert property (
        (sclIn && !stickyLockSet) [*8] |-> $stable(writeProtected))
        else $error("protection changed while bus idle");
    // Bus written protection lands while the clock is low.
    wp_rise_a: assert property (
        $rose(writeProtected) && !$past(stickyLockSet) |-> !sclIn)
        else $error("protection rose at odd time");
    // Protection falls only by a bus write, never against a set.
    wp_fall_a: assert property (
        $fell(writeProtected) && !$past(reset)
            |-> !$past(stickyLockSet) && !sclIn)
        else $error("protection fell at odd time");
endmodule

bind sib_target sib_target_assertions sib_target_assertions_i (
    .sys_clk            (sys_clk),
    .reset              (reset),
    .sclIn              (sclIn),
    .sdaIn              (sdaIn),
    .sdaOut             (sdaOut),
    .sdaOeN             (sdaOeN),
    .powerGoodPowerdownN(powerGoodPowerdownN),
    .stickyLockSet      (stickyLockSet),
    .writeProtected     (writeProtected)
);

`default_nettype wire

// ===== test/sib_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Bus controller model; both lines idle high outside frames.
module sib_host_model (
    // Clock.
    input wire logic sys_clk,
    // Bus lines, a driven 1 means released.
    input wire logic sdaWire,
    output logic     sclDrv,
    output logic     sdaDrv
);
    // Long half period so the target's sync lag fits well inside.
    localparam int HALF = 12;

    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end

    // Waits n cycles and steps just past the edge.
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Start or repeated start: data falls with the clock high.
    task automatic start();
        sdaDrv = 1'b1;
        hold(HALF);
        sclDrv = 1'b1;
        hold(HALF);
        sdaDrv = 1'b0;
        hold(HALF);
        sclDrv = 1'b0;
        hold(HALF);
    endtask

    // Stop: data rises with the clock high.
    task automatic stop();
        sdaDrv = 1'b0;
        hold(HALF);
        sclDrv = 1'b1;
        hold(HALF);
        sdaDrv = 1'b1;
        hold(HALF);
    endtask

    // One clock pulse; the wire is read late in the high phase.
    task automatic bit_x(input logic b, output logic r);
        sdaDrv = b;
        hold(HALF);
        sclDrv = 1'b1;
        hold(HALF);
        r = sdaWire;
        sclDrv = 1'b0;
    endtask

    // Sends a byte MSB first and returns the target's acknowledge.
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask

    // Takes a byte, then acknowledges unless it is the last.
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_x(1'b1, r);
            d = {d[6:0], r};
        end
        bit_x(last, r);
    endtask
endmodule

`default_nettype wire

// ===== test/sib_target_bench.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the indexed block serial target.
module sib_target_bench;
    import sib_pkg::*;

    logic       sys_clk, reset, sclDrv, sdaDrv, sdaWire;
    logic       sdaOut, sdaOeN, powerGood, stickySet, writeProtected;
    logic       ack;
    logic [7:0] rx;
    int         fails, checked, cycles;

    // Pull-up on the data wire; either party may pull it low.
    assign sdaWire = sdaDrv & (sdaOeN | sdaOut);

    sib_target sib_target_i (
        .sys_clk            (sys_clk),
        .reset              (reset),
        .sclIn              (sclDrv),
        .sdaIn              (sdaWire),
        .sdaOut             (sdaOut),
        .sdaOeN             (sdaOeN),
        .powerGoodPowerdownN(powerGood),
        .stickyLockSet      (stickySet),
        .writeProtected     (writeProtected)
    );
    sib_host_model sib_host_model_i (
        .sys_clk(sys_clk),
        .sdaWire(sdaWire),
        .sclDrv (sclDrv),
        .sdaDrv (sdaDrv)
    );

    // Clock of 40 ns.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Counts a comparison and reports a failed one.
    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // Block write of the queued bytes from offset off.
    task automatic blk_write(input logic [7:0] off, input logic [7:0] d[$],
                             input logic expAck);
        sib_host_model_i.start();
        sib_host_model_i.send({TARGET_ADDR, 1'b0}, ack);
        chk(ack === expAck, "write address ack");
        sib_host_model_i.send(off, ack);
        chk(ack === expAck, "offset ack");
        sib_host_model_i.send(8'(d.size()), ack);
        chk(ack === expAck, "count ack");
        foreach (d[i]) begin
            sib_host_model_i.send(d[i], ack);
            chk(ack === expAck, "data ack");
        end
        sib_host_model_i.stop();
    endtask

    // Block read from offset off, comparing count and every byte.
    task automatic blk_read(input logic [7:0] off, input logic [7:0] e[$]);
        sib_host_model_i.start();
        sib_host_model_i.send({TARGET_ADDR, 1'b0}, ack);
        chk(ack === 1'b1, "address ack before read");
        sib_host_model_i.send(off, ack);
        chk(ack === 1'b1, "read offset ack");
        sib_host_model_i.start();
        sib_host_model_i.send({TARGET_ADDR, 1'b1}, ack);
        chk(ack === 1'b1, "read address ack");
        sib_host_model_i.recv(1'b0, rx);
        chk(rx === 8'(e.size()), "read count");
        foreach (e[i]) begin
            sib_host_model_i.recv(i == e.size() - 1, rx);
            chk(rx === e[i], "read byte");
        end
        sib_host_model_i.stop();
    endtask

    // Reset contents come back with the reset count.
    task automatic t_reset_values();
        logic [7:0] e[$];
        chk(writeProtected === 1'b0, "protected after reset");
        for (int i = 0; i < 8; i++) begin
            e.push_back(i == COUNT_IDX ? COUNT_RESET : DATA_RESET);
        end
        blk_read(8'h00, e);
    endtask

    // Count set through byte 7, then a write read back in order.
    task automatic t_write_read();
        blk_write(COUNT_IDX, {8'h03}, 1'b1);
        blk_write(8'h02, {8'ha1, 8'hb2, 8'hc3}, 1'b1);
        blk_read(8'h02, {8'ha1, 8'hb2, 8'hc3});
    endtask

    // A foreign address is not acknowledged.
    task automatic t_addr_miss();
        sib_host_model_i.start();
        sib_host_model_i.send({TARGET_ADDR ^ 7'h01, 1'b0}, ack);
        chk(ack === 1'b0, "foreign address acked");
        sib_host_model_i.stop();
    endtask

    // Lock bit protects contents while bytes are still acked.
    task automatic t_protect();
        blk_write(LOCK_IDX, {8'h01}, 1'b1);
        chk(writeProtected === 1'b1, "lock not protecting");
        blk_write(8'h02, {8'h55}, 1'b1);
        blk_write(LOCK_IDX, {8'h00}, 1'b1);
        chk(writeProtected === 1'b0, "lock not released");
        blk_read(8'h02, {8'ha1, 8'hb2, 8'hc3});
    endtask

    // Sticky lock ignores a written zero and clears on a one.
    task automatic t_sticky();
        stickySet = 1'b1;
        sib_host_model_i.hold(1);
        stickySet = 1'b0;
        chk(writeProtected === 1'b1, "sticky not protecting");
        blk_write(LOCK_IDX, {8'h00}, 1'b1);
        chk(writeProtected === 1'b1, "sticky cleared by zero");
        blk_write(LOCK_IDX, {8'h02}, 1'b1);
        chk(writeProtected === 1'b0, "sticky not cleared");
    endtask

    // Powered-down port ignores the bus entirely.
    task automatic t_power();
        powerGood = 1'b0;
        sib_host_model_i.hold(4);
        blk_write(8'h02, {8'h66}, 1'b0);
        powerGood = 1'b1;
        sib_host_model_i.hold(4);
        blk_read(8'h02, {8'ha1, 8'hb2, 8'hc3});
    endtask

    // Store edge, lock byte readback and a protected count write.
    task automatic t_edges();
        blk_write(8'h0f, {8'h11, 8'h22, 8'h33}, 1'b1);
        blk_read(8'h0f, {8'h11, 8'h00, 8'h00});
        blk_read(8'h00, {8'h00, 8'h00, 8'ha1});
        blk_write(LOCK_IDX, {8'h01}, 1'b1);
        blk_write(COUNT_IDX, {8'h05}, 1'b1);
        blk_read(LOCK_IDX, {8'h01, 8'h00, 8'h00});
        blk_write(LOCK_IDX, {8'h00}, 1'b1);
        chk(writeProtected === 1'b0, "lock not released");
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cuts a hang short well above the expected run length.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 80000) begin
            fails++;
            $display("mismatch at %0t: run timed out", $time);
            end_sim();
        end
    end

    // Main sequence.
    initial begin
        reset = 1'b1;
        powerGood = 1'b1;
        stickySet = 1'b0;
        sib_host_model_i.hold(10);
        reset = 1'b0;
        sib_host_model_i.hold(4);
        t_reset_values();
        t_write_read();
        t_addr_miss();
        t_protect();
        t_sticky();
        t_power();
        t_edges();
        end_sim();
    end
endmodule

`default_nettype wire
